// File: hdl/frame_counter.sv
// Counts synchronised frame pulses after a start strobe.
// Assumes frame_tick_i is a one-cycle pulse in the clk_i domain.
`timescale 1ns/1ns
`default_nettype none
module frame_counter (
  input  wire logic       clk_i,        // System clock
  input  wire logic       rst_n_i,      // Synchronised reset, active low
  input  wire logic       start_i,      // Restart the count
  input  wire logic       frame_tick_i, // One frame boundary
  output logic      [1:0] frames_o      // Frames since start, saturating
);
  logic [1:0] frames_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frames_ff <= 2'h0;
    end else if (start_i) begin
      frames_ff <= 2'h0;
    end else if (frame_tick_i && frames_ff != 2'h3) begin
      frames_ff <= frames_ff + pwr_seq_pkg::FRAME_CNT_W_ONE;
    end
  end

  assign frames_o = frames_ff;
endmodule : frame_counter
`default_nettype wire

// File: hdl/pwr_seq_host.sv
// Host sequencer: drives the device reset pin and group power-on bits.
// Assumes a separate register writer applies group_power_on_bit_o to the
// device, and that the frame pulse pin is asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module pwr_seq_host #(
  parameter int unsigned POR_CYC  = pwr_seq_pkg::POR_LOW_CYC,  // Power-up reset hold
  parameter int unsigned LOCK_CYC = pwr_seq_pkg::PLL_LOCK_CYC, // PLL lock wait
  parameter int unsigned SWR_CYC  = pwr_seq_pkg::SW_RST_CYC,   // Software reset hold
  parameter bit          USE_SW   = 1'b0                        // Software reset method
) (
  input  wire logic        clk_i,                 // 25 MHz system clock
  input  wire logic        rst_n_i,               // Async reset, active low
  input  wire logic        pcm_frame_pulse_input, // Frame pulse pin, active low
  input  wire logic [15:0] group_req_i,           // Groups wanted powered
  output logic             dev_reset_n_o,         // Device reset pin, active low
  output logic      [15:0] group_power_on_bit_o,  // Group power-on bits to write
  output logic      [15:0] group_ready_o,         // Group initialised, configurable
  output logic             seq_done_o             // Bring-up sequence complete
);
  typedef enum logic [6:0] {
    ST_POR   = 7'h01,
    ST_LOCK1 = 7'h02,
    ST_PULSE = 7'h04,
    ST_SWON  = 7'h08,
    ST_SWOFF = 7'h10,
    ST_LOCK2 = 7'h20,
    ST_RUN   = 7'h40
  } state_t;

  logic [1:0]                      rst_sync_ff;
  logic                            rst_n;
  logic [1:0]                      fp_sync_ff;
  logic                            fp_prev_ff;
  logic                            frame_tick;
  state_t                          state_ff;
  logic [pwr_seq_pkg::CNT_W-1:0]   cnt_ff;
  logic                            cnt_done;
  logic                            dev_reset_n_ff;
  logic [15:0]                     pwr_ff;
  logic [15:0]                     ready_ff;
  logic                            done_ff;
  logic [15:0]                     grp_start;
  logic [1:0]                      grp_frames [16];
  logic [15:0]                     down_tick_ff;

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Frame pulse pin synchroniser; edge taken from second stage only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fp_sync_ff <= 2'h3;
      fp_prev_ff <= 1'b1;
    end else begin
      fp_sync_ff <= {fp_sync_ff[0], pcm_frame_pulse_input};
      fp_prev_ff <= fp_sync_ff[1];
    end
  end
  assign frame_tick = fp_prev_ff && !fp_sync_ff[1];

  assign cnt_done = (cnt_ff == '0);

  // Main sequence; counter reloads on each state change except ST_LOCK2 to ST_RUN
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_POR;
      cnt_ff   <= pwr_seq_pkg::CNT_W'(POR_CYC - 1);
    end else if (!cnt_done) begin
      cnt_ff <= cnt_ff - 1'b1;
    end else begin
      unique case (state_ff)
        ST_POR: begin
          state_ff <= ST_LOCK1;
          cnt_ff   <= pwr_seq_pkg::CNT_W'(LOCK_CYC - 1);
        end
        ST_LOCK1: begin
          if (USE_SW) begin
            state_ff <= ST_SWON;
            cnt_ff   <= pwr_seq_pkg::CNT_W'(SWR_CYC - 1);
          end else begin
            state_ff <= ST_PULSE;
            cnt_ff   <= pwr_seq_pkg::CNT_W'(pwr_seq_pkg::PULSE_CYC - 1);
          end
        end
        ST_SWON: begin
          state_ff <= ST_SWOFF;
          cnt_ff   <= '0;
        end
        ST_PULSE, ST_SWOFF: begin
          state_ff <= ST_LOCK2;
          cnt_ff   <= pwr_seq_pkg::CNT_W'(LOCK_CYC - 1);
        end
        ST_LOCK2: begin
          state_ff <= ST_RUN;
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_POR;
          cnt_ff   <= '0;
        end
      endcase
    end
  end

  // Reset pin low in power-up and pulse phases
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dev_reset_n_ff <= 1'b0;
    end else begin
      dev_reset_n_ff <= !((state_ff == ST_POR && !cnt_done) ||
                          (state_ff == ST_LOCK1 && cnt_done && !USE_SW) ||
                          (state_ff == ST_PULSE && !cnt_done));
    end
  end

  // Power bits: all on for software reset, else per request once locked
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= 16'h0000;
    end else if (state_ff == ST_SWON) begin
      pwr_ff <= 16'hffff;
    end else if (state_ff == ST_RUN) begin
      pwr_ff <= group_req_i & (pwr_ff | down_tick_ff);
    end else begin
      pwr_ff <= 16'h0000;
    end
  end

  // Off group must see one frame pulse in bypass before repowering, so filters clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      down_tick_ff <= 16'h0000;
    end else begin
      down_tick_ff <= ~pwr_ff & (down_tick_ff | {16{frame_tick}});
    end
  end

  // Restart frame count on rising power bit
  assign grp_start = (state_ff == ST_RUN) ?
                     (group_req_i & ~pwr_ff & down_tick_ff) : 16'h0000;

  genvar g;
  generate
    for (g = 0; g < pwr_seq_pkg::NUM_GROUPS; g++) begin : gen_grp
      frame_counter u_fc (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .start_i      (grp_start[g] || !pwr_ff[g]),
        .frame_tick_i (frame_tick),
        .frames_o     (grp_frames[g])
      );
      // Ready only after two whole frames of initialisation; tones wait on it
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          ready_ff[g] <= 1'b0;
        end else begin
          ready_ff[g] <= pwr_ff[g] && !grp_start[g] &&
                         (grp_frames[g] > 2'(pwr_seq_pkg::INIT_FRAMES));
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == ST_RUN);
    end
  end

  assign dev_reset_n_o        = dev_reset_n_ff;
  assign group_power_on_bit_o = pwr_ff;
  assign group_ready_o        = ready_ff;
  assign seq_done_o           = done_ff;

  // Assertions
  int unsigned low_run_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_run_ff <= 0;
    end else begin
      low_run_ff <= dev_reset_n_ff ? 0 : low_run_ff + 1;
    end
  end

  sequence s_pulse_end;
    $rose(dev_reset_n_ff) && state_ff == ST_LOCK2;
  endsequence

  // Counter already holds the full low width on the rising sample
  AST_PULSE_WIDTH: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_pulse_end |->
      low_run_ff >= pwr_seq_pkg::PULSE_MIN_CYC &&
      low_run_ff <= pwr_seq_pkg::PULSE_MAX_CYC)
    else $error("reset pulse width out of range");

  AST_BYPASS_FRAME: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(pwr_ff[0]) && state_ff == ST_RUN |-> $past(down_tick_ff[0]))
    else $error("group repowered without a bypass frame");

  AST_POR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_ff == ST_LOCK1 && $past(state_ff) == ST_POR |->
      $past(low_run_ff) >= POR_CYC - 1)
    else $error("power-up reset too short");

  AST_NO_PWR_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_ff == ST_LOCK2 || state_ff == ST_LOCK1 || state_ff == ST_POR |-> pwr_ff == 16'h0000)
    else $error("group powered before lock");

  AST_SW_ALL_ON: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_ff == ST_SWOFF |-> pwr_ff == 16'hffff ##1 pwr_ff == 16'h0000)
    else $error("software reset bits wrong");

  AST_READY_AFTER_INIT: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(ready_ff[0]) |-> pwr_ff[0] && $past(grp_frames[0]) > 2'h2)
    else $error("group ready before two frames");

  AST_PWR_DOWN: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_ff == ST_RUN && !group_req_i[3] |=> !pwr_ff[3] ##1 !ready_ff[3])
    else $error("group not powered down");

  AST_RELOCK: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(state_ff == ST_RUN) |-> $past(state_ff) == ST_LOCK2 && dev_reset_n_ff)
    else $error("run entered without relock");

  AST_LOCK_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(state_ff == ST_LOCK1) |-> dev_reset_n_ff [*8])
    else $error("lock wait interrupted");
endmodule : pwr_seq_host
`default_nettype wire

// File: hdl/pwr_seq_pkg.sv
// Constants for the host-side power and reset sequencer of the canceller device.
// Assumes a 25 MHz system clock and a host register port outside this block.
package pwr_seq_pkg;
  localparam int unsigned CLK_MHZ         = 25;
  localparam int unsigned NUM_GROUPS      = 16;
  // Times as specified
  localparam int unsigned POR_LOW_US      = 100;
  localparam int unsigned PLL_LOCK_US     = 500;
  localparam int unsigned PULSE_MIN_NS    = 500;
  localparam int unsigned PULSE_MAX_NS    = 1500;
  localparam int unsigned SW_RST_US       = 250;
  localparam int unsigned INIT_FRAMES     = 2;
  localparam int unsigned BYPASS_FRAMES   = 1;
  localparam int unsigned CLK_NS          = 1000 / CLK_MHZ;
  // Cycle counts: minimums round up, maximums round down
  localparam int unsigned POR_LOW_CYC     = POR_LOW_US * CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned PULSE_MIN_CYC   = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_MAX_CYC   = PULSE_MAX_NS / CLK_NS;
  localparam int unsigned PULSE_CYC       = (PULSE_MIN_CYC + PULSE_MAX_CYC) / 2;
  localparam int unsigned SW_RST_CYC      = SW_RST_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 16;
  localparam logic [1:0]  FRAME_CNT_W_ONE = 2'h1;
endpackage : pwr_seq_pkg

// File: tb/dev_model.sv
// Behavioural model of the canceller device facing the host sequencer.
// Assumes one clock; frame pulses are made here on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module dev_model #(
  parameter int FRAME = 50  // Cycles per frame
) (
  input  wire logic        clk_i,          // System clock
  input  wire logic        dev_reset_n_i,  // Reset pin, active low
  input  wire logic [15:0] power_bits_i,   // Group power-on bits
  output logic             frame_n_o,      // Frame pulse, active low
  output logic      [15:0] group_on_o,     // Groups running
  output logic             pulse_ok_o,     // Last low pulse was a register reset
  output logic      [15:0] init_done_o     // Groups through their init routine
);
  int fcnt = 0;
  int low  = 0;
  initial frame_n_o = 1'b1;
  initial pulse_ok_o = 1'b0;
  // Two cycles low so the host's sync flops cannot miss it
  always @(negedge clk_i) begin
    fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
    frame_n_o <= !(fcnt < 2);
  end
  always @(posedge clk_i) begin
    if (!dev_reset_n_i) begin
      low <= low + 1;
    end else begin
      if (low != 0) begin
        pulse_ok_o <= (low >= pwr_seq_pkg::PULSE_MIN_CYC) && (low <= pwr_seq_pkg::PULSE_MAX_CYC);
      end
      low <= 0;
    end
  end
  // Reset halts and clears every group; only written groups run, the rest bypass
  always @(posedge clk_i or negedge dev_reset_n_i) begin
    if (!dev_reset_n_i) group_on_o <= 16'h0000;
    else group_on_o <= power_bits_i;
  end
  // Rising power bit reloads defaults; init needs two frame starts
  logic [15:0] prev_bits = 16'h0000;
  int          seen [16];
  always @(posedge clk_i) begin
    prev_bits <= power_bits_i;
    for (int g = 0; g < 16; g++) begin
      if (!dev_reset_n_i || !power_bits_i[g]) seen[g] <= 0;
      else if (!prev_bits[g]) seen[g] <= 0;
      else if (fcnt == 0 && seen[g] < 2) seen[g] <= seen[g] + 1;
      init_done_o[g] <= dev_reset_n_i && power_bits_i[g] && prev_bits[g] && seen[g] >= 2;
    end
  end
endmodule : dev_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the host power sequencer, both reset methods.
// Assumes shortened wait parameters; the device model supplies frame pulses.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int POR = 60;
  localparam int LOCK = 40;
  localparam int SWR = 20;
  localparam int F = 50;
  logic        clk_i = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] req   = 16'h0000;
  wire         frame_n;
  wire         dev_rst_n;
  wire         sw_rst_n;
  wire         seq_done;
  wire         sw_done;
  wire         pulse_ok;
  wire  [15:0] bits;
  wire  [15:0] sw_bits;
  wire  [15:0] ready;
  wire  [15:0] model_on;
  wire  [15:0] init_done;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  pwr_seq_host #(.POR_CYC(POR), .LOCK_CYC(LOCK), .SWR_CYC(SWR), .USE_SW(1'b0)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n), .pcm_frame_pulse_input(frame_n), .group_req_i(req),
    .dev_reset_n_o(dev_rst_n), .group_power_on_bit_o(bits), .group_ready_o(ready),
    .seq_done_o(seq_done));
  pwr_seq_host #(.POR_CYC(POR), .LOCK_CYC(LOCK), .SWR_CYC(SWR), .USE_SW(1'b1)) u_dut_sw (
    .clk_i(clk_i), .rst_n_i(rst_n), .pcm_frame_pulse_input(frame_n), .group_req_i(req),
    .dev_reset_n_o(sw_rst_n), .group_power_on_bit_o(sw_bits), .group_ready_o(),
    .seq_done_o(sw_done));
  dev_model #(.FRAME(F)) u_model (
    .clk_i(clk_i), .dev_reset_n_i(dev_rst_n), .power_bits_i(bits),
    .frame_n_o(frame_n), .group_on_o(model_on), .pulse_ok_o(pulse_ok),
    .init_done_o(init_done));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_vec
  task automatic chk_cnt(input bit ok, input int n, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("ERROR %0t %s count %0d", $time, m, n);
    end
  endtask : chk_cnt
  function automatic logic pick(input int s);
    case (s)
      0: return dev_rst_n;
      1: return seq_done;
      2: return sw_bits[0];
      3: return sw_rst_n;
      default: return sw_done;
    endcase
  endfunction : pick
  // Cycles for which the chosen output keeps the given level, seen when settled
  task automatic span(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) === lvl && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : span
  task automatic t_hw_reset;
    int n;
    span(0, 1'b0, n);
    chk_cnt(n >= POR, n, "power-up hold");
    span(0, 1'b1, n);
    chk_cnt(n >= LOCK, n, "lock wait");
    span(0, 1'b0, n);
    chk_cnt(n >= pwr_seq_pkg::PULSE_MIN_CYC && n <= pwr_seq_pkg::PULSE_MAX_CYC, n,
            "second pulse");
    chk_vec(bits, 16'h0000, "bits before run");
    span(1, 1'b0, n);
    chk_cnt(n >= LOCK, n, "relock wait");
    chk_vec({15'h0000, pulse_ok}, 16'h0001, "register reset seen");
  endtask : t_hw_reset
  task automatic t_sw_reset;
    int n;
    span(3, 1'b0, n);
    chk_cnt(n >= POR, n, "power-up hold sw");
    span(2, 1'b0, n);
    chk_cnt(n >= LOCK, n, "lock wait sw");
    chk_vec(sw_bits, 16'hffff, "all bits set");
    span(2, 1'b1, n);
    chk_cnt(n >= SWR, n, "sw reset hold");
    chk_vec(sw_bits, 16'h0000, "all bits cleared");
    span(4, 1'b0, n);
    chk_cnt(n >= LOCK, n, "relock wait sw");
    chk_vec({15'h0000, sw_rst_n}, 16'h0001, "no pin pulse");
  endtask : t_sw_reset
  task automatic t_groups;
    @(negedge clk_i);
    req = 16'h8009;
    repeat (2) @(negedge clk_i);
    chk_vec(bits, 16'h8009, "bits follow request");
    chk_vec(model_on, 16'h8009, "device groups");
    repeat (F - 4) @(negedge clk_i);
    chk_vec(ready, 16'h0000, "ready too early");
    repeat (3 * F) @(negedge clk_i);
    chk_vec(ready, 16'h8009, "ready after frames");
    chk_vec(init_done, 16'h8009, "device init done");
    chk_vec(ready & ~init_done, 16'h0000, "ready before device init");
    req = 16'h8000;
    repeat (3) @(negedge clk_i);
    chk_vec(bits, 16'h8000, "groups down");
    chk_vec(ready, 16'h8000, "ready after down");
    chk_vec(model_on, 16'h8000, "device groups down");
    req = 16'h8001;
    repeat (F + 8) @(negedge clk_i);
    chk_vec(bits, 16'h8001, "group back after bypass");
    chk_vec(ready, 16'h8000, "ready rearmed");
  endtask : t_groups
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n = 1'b1;
    fork
      t_hw_reset();
      t_sw_reset();
    join
    t_groups();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
